// file: verilog/pmrc_pkg.sv
package pmrc_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] PMRC_OFS_CTRL  = 8'h00;  // reset and oscillator control
	localparam logic [7:0] PMRC_OFS_PERI  = 8'h01;  // stop-mode peripheral options
	localparam logic [7:0] PMRC_OFS_STAB  = 8'h02;  // wake stabilisation count
	localparam logic [7:0] PMRC_OFS_STAT  = 8'h03;  // current mode, read only
	localparam logic [7:0] PMRC_OFS_CAUSE = 8'h04;  // reset causes, write one to clear

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int PMRC_CTRL_WDT_RST_EN = 0;  // watchdog_reset_enable
	localparam int PMRC_CTRL_LVR_DIS_N  = 1;  // low_voltage_reset_disable_n
	localparam int PMRC_CTRL_LFRC_STOP  = 2;  // low freq rc runs in stop
	localparam int PMRC_CTRL_WDRC_EN    = 3;  // watchdog rc oscillator enable
	localparam int PMRC_CTRL_WDT_RC_SRC = 4;  // watchdog clocked from an rc oscillator
	localparam int PMRC_CTRL_W          = 5;

	// ----------------------------------------
	// peripheral option fields
	// ----------------------------------------
	localparam int PMRC_PERI_T0_EVT   = 0;  // timer 0 event-counter mode
	localparam int PMRC_PERI_T0_SLOW  = 1;  // timer 0 on sub or low freq rc clock
	localparam int PMRC_PERI_T1_EVT   = 2;  // timer 1 event-counter mode
	localparam int PMRC_PERI_T2_EVT   = 3;  // timer 2 event-counter mode
	localparam int PMRC_PERI_RTC_SUB  = 4;  // calendar unit on sub oscillator
	localparam int PMRC_PERI_UART_SUB = 5;  // low power uart on sub oscillator
	localparam int PMRC_PERI_I2C_EXT  = 6;  // i2c serial clock from outside
	localparam int PMRC_PERI_SPI_EXT  = 7;  // spi serial clock from outside

	// ----------------------------------------
	// reset cause fields
	// ----------------------------------------
	localparam int PMRC_CAUSE_EXT = 0;
	localparam int PMRC_CAUSE_POR = 1;
	localparam int PMRC_CAUSE_WDT = 2;
	localparam int PMRC_CAUSE_LVR = 3;
	localparam int PMRC_CAUSE_OCD = 4;
	localparam int PMRC_CAUSE_W   = 5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [PMRC_CTRL_W-1:0] PMRC_CTRL_RST = 5'h0A;  // lvr disarmed, wdt rc on
	localparam logic [7:0]  PMRC_PERI_RST = 8'h00;
	localparam logic [7:0]  PMRC_STAB_RST = 8'h04;  // interval timer overflows
	localparam logic [15:0] PMRC_PC_RST   = 16'h0000;
	localparam logic [7:0]  PMRC_ACC_RST  = 8'h00;
	localparam logic [7:0]  PMRC_SP_RST   = 8'h07;
	localparam logic [7:0]  PMRC_ZERO8    = 8'h00;
	localparam logic [3:0]  PMRC_RST_HOLD = 4'h8;  // stretch of system reset, cycles
	localparam logic [3:0]  PMRC_ZERO4    = 4'h0;
	localparam logic [3:0]  PMRC_ONE4     = 4'h1;
	localparam logic [7:0]  PMRC_ONE8     = 8'h01;

	// ----------------------------------------
	// power modes, gray along stop-wake-run
	// ----------------------------------------
	typedef enum logic [1:0] {
		PMRC_RUN  = 2'h0,
		PMRC_IDLE = 2'h1,
		PMRC_STOP = 2'h3,
		PMRC_WAKE = 2'h2
	} pmrc_state_t;

endpackage

// file: verilog/pmrc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-stage synchroniser for pin levels
// ----------------------------------------
module pmrc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         arst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] meta_q;  // first stage, read by second stage only

	// plain double flop; reset state means inactive
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: verilog/pmrc_top.sv
// Contract
// - low-power modes halt cpu, state retained
// - stop halts watchdog unless rc clocked
// - stop halts timer0 unless event/slow clock
// - stop halts timers 1,2 unless event mode
// - calendar and uart run on sub clock
// - i2c, spi run in stop on external clock
// - rc oscillators follow their enable settings
// - idle ends on any reset or interrupt
// - stop ends only on reset or listed wake interrupts
// - reset loads pc 0000, acc 00, sp 07
// - five reset sources form one system reset
// - watchdog reset only when enable is one
// - low-voltage reset only when control reads zero
// - stop exit waits interval timer stabilisation
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pmrc_top
	import pmrc_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	// register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	// cpu mode requests, one-cycle pulses
	input  wire logic        cpu_idle_req_in,
	input  wire logic        cpu_stop_req_in,
	// interrupt requests, same clock
	input  wire logic        irq_pending_in,
	input  wire logic        t0_irq_in,
	input  wire logic        t1_irq_in,
	input  wire logic        t2_irq_in,
	input  wire logic        ext_irq_in,
	input  wire logic        wdt_irq_in,
	input  wire logic        low_power_uart_irq_in,
	input  wire logic        calendar_clock_unit_irq_in,
	input  wire logic        bit_ovf_in,
	// reset sources
	input  wire logic        external_reset_pin_n_in,
	input  wire logic        por_n_in,
	input  wire logic        wdt_overflow_in,
	input  wire logic        lvd_in,
	input  wire logic        ocd_reset_req_in,
	// reset results
	output logic             sys_reset_out,
	output logic      [15:0] pc_rst_out,
	output logic      [7:0]  acc_rst_out,
	output logic      [7:0]  sp_rst_out,
	// clock gating
	output logic             cpu_clk_en_out,
	output logic             bit_clk_en_out,
	output logic             wdt_clk_en_out,
	output logic             t0_clk_en_out,
	output logic             t1_clk_en_out,
	output logic             t2_clk_en_out,
	output logic             calendar_clock_unit_clk_en_out,
	output logic             adc_clk_en_out,
	output logic             low_power_uart_clk_en_out,
	output logic             i2c_clk_en_out,
	output logic             spi_clk_en_out,
	output logic             hfirc_en_out,
	output logic             low_freq_rc_oscillator_en_out,
	output logic             watchdog_rc_oscillator_en_out,
	output logic      [1:0]  mode_out
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_s;  // ext pin, por, low supply, active high

	pmrc_sync #(
		.W(3)
	) u_sync (
		.clk_in   (ref_clk_in),
		.arst_n_in(arst_n_in),
		.d_in     ({lvd_in, ~por_n_in, ~external_reset_pin_n_in}),
		.q_out    (pin_s)
	);

	wire ext_rst_s = pin_s[0];
	wire por_s     = pin_s[1];
	wire lvd_s     = pin_s[2];

	// ----------------------------------------
	// registers and decode
	// ----------------------------------------
	logic [PMRC_CTRL_W-1:0]  ctrl_q;   // reset and oscillator control
	logic [7:0]              peri_q;   // stop-mode peripheral options
	logic [7:0]              stab_q;   // overflows to wait after stop
	logic [PMRC_CAUSE_W-1:0] cause_q;  // sticky reset causes
	logic [7:0]              rdata_d;
	pmrc_state_t             state_q;
	pmrc_state_t             state_d;
	logic                    sys_rst_q;

	wire wr_ctrl  = reg_wr_in && (reg_addr_in == PMRC_OFS_CTRL);
	wire wr_peri  = reg_wr_in && (reg_addr_in == PMRC_OFS_PERI);
	wire wr_stab  = reg_wr_in && (reg_addr_in == PMRC_OFS_STAB);
	wire wr_cause = reg_wr_in && (reg_addr_in == PMRC_OFS_CAUSE);

	wire watchdog_reset_enable       = ctrl_q[PMRC_CTRL_WDT_RST_EN];
	wire low_voltage_reset_disable_n = ctrl_q[PMRC_CTRL_LVR_DIS_N];

	// ----------------------------------------
	// reset combination
	// ----------------------------------------
	wire wdt_rst = wdt_overflow_in && watchdog_reset_enable;
	wire lvr_rst = lvd_s && !low_voltage_reset_disable_n;

	// any source raises the one system reset
	wire rst_any = ext_rst_s | por_s | wdt_rst | lvr_rst | ocd_reset_req_in;

	wire [PMRC_CAUSE_W-1:0] cause_set = {
		ocd_reset_req_in, lvr_rst, wdt_rst, por_s, ext_rst_s
	};

	logic [3:0] hold_q;  // stretch so short glitches still reset fully
	wire  [3:0] hold_d = rst_any ? PMRC_RST_HOLD :
	                     (hold_q != PMRC_ZERO4) ? (hold_q - PMRC_ONE4) : PMRC_ZERO4;

	// system reset held while a source is active and a few cycles after
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hold_q    <= PMRC_RST_HOLD;
			sys_rst_q <= 1'b1;
		end else begin
			hold_q    <= hold_d;
			sys_rst_q <= rst_any || (hold_q != PMRC_ZERO4);
		end
	end

	// causes survive the system reset; a new event beats the clear
	wire [PMRC_CAUSE_W-1:0] cause_clr = wr_cause ? reg_wdata_in[PMRC_CAUSE_W-1:0] : '0;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~cause_clr) | cause_set;
		end
	end

	// ----------------------------------------
	// core reset values
	// ----------------------------------------
	// constants held in flops so they meet the core as clean data
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pc_rst_out  <= PMRC_PC_RST;
			acc_rst_out <= PMRC_ACC_RST;
			sp_rst_out  <= PMRC_SP_RST;
		end else begin
			pc_rst_out  <= PMRC_PC_RST;
			acc_rst_out <= PMRC_ACC_RST;
			sp_rst_out  <= PMRC_SP_RST;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	// control state returns to defaults on every system reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_q <= PMRC_CTRL_RST;
			peri_q <= PMRC_PERI_RST;
			stab_q <= PMRC_STAB_RST;
		end else if (sys_rst_q) begin
			ctrl_q <= PMRC_CTRL_RST;
			peri_q <= PMRC_PERI_RST;
			stab_q <= PMRC_STAB_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_in[PMRC_CTRL_W-1:0];
			end
			if (wr_peri) begin
				peri_q <= reg_wdata_in;
			end
			if (wr_stab) begin
				stab_q <= reg_wdata_in;
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_d = PMRC_ZERO8;
		case (reg_addr_in)
			PMRC_OFS_CTRL: begin
				rdata_d[PMRC_CTRL_W-1:0] = ctrl_q;
			end
			PMRC_OFS_PERI: begin
				rdata_d = peri_q;
			end
			PMRC_OFS_STAB: begin
				rdata_d = stab_q;
			end
			PMRC_OFS_STAT: begin
				rdata_d[1:0] = state_q;
			end
			PMRC_OFS_CAUSE: begin
				rdata_d[PMRC_CAUSE_W-1:0] = cause_q;
			end
			default: begin
				rdata_d = PMRC_ZERO8;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= PMRC_ZERO8;
		end else begin
			reg_rdata_out <= reg_rd_in ? rdata_d : PMRC_ZERO8;
		end
	end

	// ----------------------------------------
	// power mode sequencer
	// ----------------------------------------
	// only these sources, or a system reset, may end stop mode
	wire stop_wake = t0_irq_in | t1_irq_in | t2_irq_in | ext_irq_in |
	                 wdt_irq_in | low_power_uart_irq_in | calendar_clock_unit_irq_in;

	logic [7:0] stab_cnt_q;  // interval timer overflows seen since wake
	wire        stab_done = (stab_cnt_q >= stab_q);

	always_comb begin
		state_d = state_q;
		case (state_q)
			PMRC_RUN: begin
				// stop wins when both requests coincide
				if (cpu_stop_req_in) begin
					state_d = PMRC_STOP;
				end else if (cpu_idle_req_in) begin
					state_d = PMRC_IDLE;
				end
			end
			PMRC_IDLE: begin
				if (irq_pending_in) begin
					state_d = PMRC_RUN;
				end
			end
			PMRC_STOP: begin
				if (stop_wake) begin
					state_d = PMRC_WAKE;
				end
			end
			PMRC_WAKE: begin
				// cpu clock only after the oscillator has settled
				if (stab_done) begin
					state_d = PMRC_RUN;
				end
			end
			default: begin
				state_d = PMRC_RUN;
			end
		endcase
	end

	// any system reset forces run, so idle and stop end on reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= PMRC_RUN;
		end else if (sys_rst_q) begin
			state_q <= PMRC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// count interval timer overflows while waking
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stab_cnt_q <= PMRC_ZERO8;
		end else if (state_q != PMRC_WAKE) begin
			stab_cnt_q <= PMRC_ZERO8;
		end else if (bit_ovf_in && !stab_done) begin
			stab_cnt_q <= stab_cnt_q + PMRC_ONE8;
		end
	end

	// ----------------------------------------
	// clock enable decode
	// ----------------------------------------
	wire in_run  = (state_q == PMRC_RUN);
	wire in_stop = (state_q == PMRC_STOP);

	// cpu gated in idle, stop and wake; registers and ram are untouched
	// and the pending interrupt is left for the core to take on resume
	wire cpu_en_d  = in_run;
	wire hfirc_d   = !in_stop;
	wire bit_en_d  = !in_stop;
	wire adc_en_d  = !in_stop;
	wire wdt_en_d  = !in_stop || ctrl_q[PMRC_CTRL_WDT_RC_SRC];
	wire t0_en_d   = !in_stop || peri_q[PMRC_PERI_T0_EVT] ||
	                 peri_q[PMRC_PERI_T0_SLOW];
	wire t1_en_d   = !in_stop || peri_q[PMRC_PERI_T1_EVT];
	wire t2_en_d   = !in_stop || peri_q[PMRC_PERI_T2_EVT];
	wire rtc_en_d  = !in_stop || peri_q[PMRC_PERI_RTC_SUB];
	wire uart_en_d = !in_stop || peri_q[PMRC_PERI_UART_SUB];
	wire i2c_en_d  = !in_stop || peri_q[PMRC_PERI_I2C_EXT];
	wire spi_en_d  = !in_stop || peri_q[PMRC_PERI_SPI_EXT];
	wire lfrc_d    = !in_stop || ctrl_q[PMRC_CTRL_LFRC_STOP];
	wire wdrc_d    = ctrl_q[PMRC_CTRL_WDRC_EN];

	// registered enables; peripheral clocks on through reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cpu_clk_en_out    <= 1'b1;
			hfirc_en_out      <= 1'b1;
			bit_clk_en_out    <= 1'b1;
			adc_clk_en_out    <= 1'b1;
			wdt_clk_en_out    <= 1'b1;
			t0_clk_en_out     <= 1'b1;
			t1_clk_en_out     <= 1'b1;
			t2_clk_en_out     <= 1'b1;
			calendar_clock_unit_clk_en_out   <= 1'b1;
			low_power_uart_clk_en_out <= 1'b1;
			i2c_clk_en_out    <= 1'b1;
			spi_clk_en_out    <= 1'b1;
			low_freq_rc_oscillator_en_out      <= 1'b1;
			watchdog_rc_oscillator_en_out      <= 1'b1;
			mode_out          <= PMRC_RUN;
		end else begin
			cpu_clk_en_out    <= cpu_en_d;
			hfirc_en_out      <= hfirc_d;
			bit_clk_en_out    <= bit_en_d;
			adc_clk_en_out    <= adc_en_d;
			wdt_clk_en_out    <= wdt_en_d;
			t0_clk_en_out     <= t0_en_d;
			t1_clk_en_out     <= t1_en_d;
			t2_clk_en_out     <= t2_en_d;
			calendar_clock_unit_clk_en_out   <= rtc_en_d;
			low_power_uart_clk_en_out <= uart_en_d;
			i2c_clk_en_out    <= i2c_en_d;
			spi_clk_en_out    <= spi_en_d;
			low_freq_rc_oscillator_en_out      <= lfrc_d;
			watchdog_rc_oscillator_en_out      <= wdrc_d;
			mode_out          <= state_q;
		end
	end

	assign sys_reset_out = sys_rst_q;

endmodule

`default_nettype wire

// file: verif/pmrc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module pmrc_top_props (
	input wire logic       ref_clk_in,
	input wire logic       arst_n_in,
	input wire logic       irq_pending_in,
	input wire logic       t0_irq_in,
	input wire logic       t1_irq_in,
	input wire logic       t2_irq_in,
	input wire logic       ext_irq_in,
	input wire logic       wdt_irq_in,
	input wire logic       low_power_uart_irq_in,
	input wire logic       calendar_clock_unit_irq_in,
	input wire logic       external_reset_pin_n_in,
	input wire logic       ocd_reset_req_in,
	input wire logic       sys_reset_out,
	input wire logic       cpu_clk_en_out,
	input wire logic       hfirc_en_out,
	input wire logic       bit_clk_en_out,
	input wire logic       adc_clk_en_out,
	input wire logic [1:0] mode_out
);
	// ----------------------------------------
	// common clocking
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	// any of the seven stop-mode wake sources
	wire logic wake_any;
	assign wake_any = t0_irq_in | t1_irq_in | t2_irq_in | ext_irq_in | wdt_irq_in
		| low_power_uart_irq_in | calendar_clock_unit_irq_in;

	// ----------------------------------------
	// mode, gating and reset
	// ----------------------------------------
	stop_halt_a : assert property (
		mode_out == 2'h3 |-> !cpu_clk_en_out && !hfirc_en_out && !bit_clk_en_out
		&& !adc_clk_en_out) else $error("core or fast clocks running in stop");
	idle_core_a : assert property (
		mode_out == 2'h1 |-> !cpu_clk_en_out && hfirc_en_out && bit_clk_en_out
		&& adc_clk_en_out) else $error("idle gating wrong");
	wake_hold_a : assert property (
		mode_out == 2'h2 |-> !cpu_clk_en_out && hfirc_en_out && bit_clk_en_out)
		else $error("wake gating wrong");
	idle_exit_a : assert property (
		mode_out == 2'h1 && irq_pending_in |-> ##[1:2] mode_out == 2'h0)
		else $error("idle not left on interrupt");
	stop_stay_a : assert property (
		(mode_out == 2'h3 && !wake_any && !sys_reset_out) [*2] |=> mode_out == 2'h3)
		else $error("stop left without wake source");
	stop_wake_a : assert property (
		mode_out == 2'h3 && wake_any && !sys_reset_out |-> ##[1:2] mode_out == 2'h2)
		else $error("wake source did not end stop");
	ocd_reset_a : assert property (
		$rose(ocd_reset_req_in) |-> ##[1:2] sys_reset_out)
		else $error("debugger reset not taken");
	pin_reset_a : assert property (
		$fell(external_reset_pin_n_in) |-> ##[1:4] sys_reset_out)
		else $error("reset pin not taken");
	reset_hold_a : assert property (
		$rose(sys_reset_out) |-> sys_reset_out [*8])
		else $error("system reset too short");

	// main scenarios reached
	cover property (mode_out == 2'h2 ##1 mode_out == 2'h0);
	cover property (mode_out == 2'h1 && irq_pending_in);
	cover property ($rose(sys_reset_out));
endmodule

bind pmrc_top pmrc_top_props u_props (.ref_clk_in, .arst_n_in, .irq_pending_in,
	.t0_irq_in, .t1_irq_in, .t2_irq_in, .ext_irq_in, .wdt_irq_in, .low_power_uart_irq_in,
	.calendar_clock_unit_irq_in, .external_reset_pin_n_in, .ocd_reset_req_in, .sys_reset_out,
	.cpu_clk_en_out, .hfirc_en_out, .bit_clk_en_out, .adc_clk_en_out, .mode_out);

`default_nettype wire

// file: verif/pmrc_bit_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// interval timer on the far side
// ----------------------------------------
module pmrc_bit_model #(
	parameter int PERIOD = 5  // cycles between overflows
) (
	input  wire logic ref_clk_in,
	input  wire logic arst_n_in,
	input  wire logic bit_clk_en_in,
	output logic      bit_ovf_out
);
	int cnt_q;  // count holds while gated, like a real stopped timer

	// one-cycle overflow pulse only while clocked
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 0;
			bit_ovf_out <= 1'b0;
		end else if (bit_clk_en_in) begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			bit_ovf_out <= (cnt_q == PERIOD - 1);
		end else begin
			bit_ovf_out <= 1'b0;  // gated: no pulses
		end
	end
endmodule

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	import pmrc_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in, irq_pending_in;
	logic        cpu_idle_req_in, cpu_stop_req_in, bit_ovf_in, sys_reset_out;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, acc_rst_out, sp_rst_out;
	logic [15:0] pc_rst_out;
	logic [1:0]  mode_out;
	logic [6:0]  wk;    // wake interrupts, t0 t1 t2 ext wdt uart calendar_clock_unit
	logic [4:0]  rsrc;  // reset sources, high = asserted
	wire  [13:0] en;    // all clock and oscillator enables, one design port per bit
	logic [31:0] r;
	logic [7:0]  d, c, p;
	int          errors, checked, i, k, n, s, e;
	int          cq[$];  // expected cause words, oldest first

	always #12.5 ref_clk_in = ~ref_clk_in;

	pmrc_top uut (.ref_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .cpu_idle_req_in, .cpu_stop_req_in, .irq_pending_in,
		.t0_irq_in(wk[0]), .t1_irq_in(wk[1]), .t2_irq_in(wk[2]), .ext_irq_in(wk[3]),
		.wdt_irq_in(wk[4]), .low_power_uart_irq_in(wk[5]), .calendar_clock_unit_irq_in(wk[6]), .bit_ovf_in,
		.external_reset_pin_n_in(~rsrc[0]), .por_n_in(~rsrc[1]), .wdt_overflow_in(rsrc[2]),
		.lvd_in(rsrc[3]), .ocd_reset_req_in(rsrc[4]), .sys_reset_out, .pc_rst_out,
		.acc_rst_out, .sp_rst_out, .cpu_clk_en_out(en[13]), .bit_clk_en_out(en[12]),
		.wdt_clk_en_out(en[11]), .t0_clk_en_out(en[10]), .t1_clk_en_out(en[9]),
		.t2_clk_en_out(en[8]), .calendar_clock_unit_clk_en_out(en[7]), .adc_clk_en_out(en[6]),
		.low_power_uart_clk_en_out(en[5]), .i2c_clk_en_out(en[4]), .spi_clk_en_out(en[3]),
		.hfirc_en_out(en[2]), .low_freq_rc_oscillator_en_out(en[1]), .watchdog_rc_oscillator_en_out(en[0]), .mode_out);

	// far-side interval timer, paces the wake wait
	pmrc_bit_model u_bit (.ref_clk_in, .arst_n_in, .bit_clk_en_in(en[12]),
		.bit_ovf_out(bit_ovf_in));

	// ----------------------------------------
	// reference model and helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// expected enables per mode from control and option bytes
	function automatic logic [13:0] exp_en(input int m, input int cv, input int pv);
		if (m == 3) begin
			return {2'h0, cv[4], pv[0] | pv[1], pv[2], pv[3], pv[4], 1'b0, pv[5], pv[6],
				pv[7], 1'b0, cv[2], cv[3]};
		end
		return {m == 0, 12'hFFF, cv[3]};
	endfunction

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask

	// read data taken in the single cycle it stands
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask

	task req(input logic [1:0] v);
		@(posedge ref_clk_in);
		{cpu_stop_req_in, cpu_idle_req_in} <= v;
		@(posedge ref_clk_in);
		{cpu_stop_req_in, cpu_idle_req_in} <= 2'h0;
	endtask

	// bounded wait for a mode or for reset to end
	task wm(input logic [1:0] m);
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1 n++;
		end while (mode_out !== m && n < 300);
		chk("mode", mode_out, m);
	endtask

	task wsr;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			#1 n++;
		end while (sys_reset_out !== 1'b0 && n < 60);
		chk("reset_end", sys_reset_out, 0);
	endtask

	task test_done;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog against hangs
	// ----------------------------------------
	initial begin
		#(25 * 20000);
		errors++;
		test_done();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{ref_clk_in, arst_n_in, reg_wr_in, reg_rd_in, irq_pending_in} = 5'h00;
		{cpu_idle_req_in, cpu_stop_req_in, wk, rsrc} = 14'h0000;
		{reg_addr_in, reg_wdata_in} = 16'h0000;
		r = 32'hB7C3C387;
		repeat (8) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		wsr();
		chk("pc", pc_rst_out, 16'h0000);
		chk("acc_sp", {acc_rst_out, sp_rst_out}, 16'h0007);
		chk("run_en", en, exp_en(0, 8'h0A, 0));
		// read-only status and unmapped offset ignore writes
		wr(8'h03, 8'hFF);
		wr(8'h07, 8'hFF);
		rd(8'h00, d);
		chk("ctrl", d, 8'h0A);
		rd(8'h02, d);
		chk("stab", d, 8'h04);
		rd(8'h03, d);
		chk("stat", d, 8'h00);
		rd(8'h07, d);
		chk("unmapped", d, 8'h00);
		// idle: stop request refused, interrupt ends it
		req(2'h1);
		wm(2'h1);
		chk("idle_en", en, exp_en(1, 8'h0A, 0));
		req(2'h2);
		repeat (3) @(posedge ref_clk_in);
		#1 chk("idle_keep", mode_out, 2'h1);
		@(posedge ref_clk_in);
		irq_pending_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		#1 chk("idle_exit", mode_out, 2'h0);
		@(posedge ref_clk_in);
		irq_pending_in <= 1'b0;
		// stop with random options, each wake source once
		for (k = 0; k < 7; k++) begin
			r = lfsr(r);
			c = {3'h0, r[4:2], 2'h2};
			p = r[15:8];
			s = r[17:16] + 1;
			wr(8'h00, c);
			wr(8'h01, p);
			wr(8'h02, s[7:0]);
			rd(8'h01, d);
			chk("peri", d, p);
			// first pass raises both requests at once: stop must win
			req((k == 0) ? 2'h3 : 2'h2);
			wm(2'h3);
			chk("stop_en", en, exp_en(3, c, p));
			@(posedge ref_clk_in);
			irq_pending_in <= 1'b1;
			repeat (6) @(posedge ref_clk_in);
			#1 chk("stop_keep", mode_out, 2'h3);
			@(posedge ref_clk_in);
			irq_pending_in <= 1'b0;
			wk[k] <= 1'b1;
			wm(2'h2);
			chk("wake_en", en, exp_en(2, c, p));
			i = 1;
			do begin
				@(posedge ref_clk_in);
				#1 i++;
			end while (mode_out === 2'h2 && i < 60);
			chk("wake_len", (i > (s - 1) * 5 && i <= s * 5 + 4), 1);
			chk("resume", {mode_out, en}, {2'h0, exp_en(0, c, p)});
			@(posedge ref_clk_in);
			wk <= 7'h00;
		end
		// each reset source, watchdog and low voltage also unarmed
		for (i = 0; i < 10; i++) begin
			k = i / 2;
			wr(8'h00, (i % 2) ? 8'h09 : 8'h0A);
			if (i == 0) begin
				req(2'h2);
				wm(2'h3);
			end
			e = (k == 2 || k == 3) ? i % 2 : 1;
			cq.push_back(e << k);
			@(posedge ref_clk_in);
			rsrc[k] <= 1'b1;
			repeat (4) @(posedge ref_clk_in);
			rsrc[k] <= 1'b0;
			#1 chk("sys_reset", sys_reset_out, e);
			wsr();
			chk("reset_mode", mode_out, 2'h0);
			rd(8'h04, d);
			chk("cause", d, cq.pop_front());
			rd(8'h00, d);
			chk("ctrl_after", d, (e == 1) ? 8'h0A : 8'h0A - (i % 2));
			wr(8'h04, 8'h1F);
		end
		test_done();
	end
endmodule

`default_nettype wire
